// ==== shared/pllcfg_params.svh ====
/*
  Constants for the PLL divider configuration block: register offsets, control field
  positions, reset values, divider tables and timing counts.
  Assumes it is included by bare name from the shared folder.
*/
`ifndef PLLCFG_PARAMS_SVH
`define PLLCFG_PARAMS_SVH

`define PLLCFG_CLOCK_MHZ 250
`define PLLCFG_LOCK_TIME_MS 10
`define PLLCFG_LOCK_CNT_W 22
`define PLLCFG_LOCK_CYCLES (`PLLCFG_LOCK_TIME_MS * 1000 * `PLLCFG_CLOCK_MHZ)

`define PLLCFG_ADDR_W 4
`define PLLCFG_REG_CTRL 4'h0
`define PLLCFG_REG_STATUS 4'h4
`define PLLCFG_REG_RATIO 4'h8
`define PLLCFG_REG_PERIOD 4'hc

`define PLLCFG_CTRL_SRC_LSB 0
`define PLLCFG_CTRL_BYPASS_BIT 2
`define PLLCFG_CTRL_RELOCK_BIT 3
`define PLLCFG_CTRL_SRC_RESET 2'h0
`define PLLCFG_CTRL_BYPASS_RESET 1'h0

`define PLLCFG_RESP_OKAY 2'h0
`define PLLCFG_RESP_SLVERR 2'h2

// Half ratios, one 5-bit entry per select code, code 0 in the low bits.
`define PLLCFG_FB_HALVES {5'h0a, 5'h0a, 5'h08, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02}
`define PLLCFG_A_HALVES {5'h06, 5'h04, 5'h03, 5'h02}
`define PLLCFG_B_HALVES {5'h05, 5'h04, 5'h03, 5'h02}
`define PLLCFG_C_HALVES {5'h04, 5'h03, 5'h02, 5'h01}
`define PLLCFG_FB_DIV1_MAX_CODE 3'h5

`define PLLCFG_GAP_MAX 16'hffff

`endif

// ==== shared/pllcfg_pkg.sv ====
/*
  Types shared by the PLL divider configuration block.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package pllcfg_pkg;
  typedef logic [2:0] pllcfg_fb_sel_t;
  typedef logic [1:0] pllcfg_bank_sel_t;
  typedef logic [4:0] pllcfg_half_t;
  typedef logic [7:0] pllcfg_ratio_t;
  typedef enum logic [1:0] {
    PLLCFG_SRC_IN0 = 2'h0,
    PLLCFG_SRC_IN1 = 2'h1,
    PLLCFG_SRC_CRYSTAL_REFERENCE = 2'h2,
    PLLCFG_SRC_CRYSTAL_REFERENCE_ALT = 2'h3
  } pllcfg_src_e;
  typedef enum logic [1:0] {
    PLLCFG_LK_HUNT = 2'h0,
    PLLCFG_LK_SETTLE = 2'h1,
    PLLCFG_LK_LOCKED = 2'h3
  } pllcfg_lock_e;
endpackage

`default_nettype wire

// ==== src/pllcfg_divider.sv ====
/*
  Even-ratio clock divider driven by one-cycle tick pulses; the output toggles every
  half ticks, so its period is twice half ticks.
  Assumes tick is synchronous to clock and half is never zero.
*/
`default_nettype none

module pllcfg_divider (
  input wire logic clock,
  input wire logic reset,
  input wire logic tick,
  input wire pllcfg_pkg::pllcfg_half_t half,
  output logic div_out
);
  import pllcfg_pkg::*;

  pllcfg_half_t count_r;
  logic out_r;

  // A ratio cut below the count while counting rolls over at once, so no long glitch period appears.
  always_ff @(posedge clock) begin
    if (reset) begin
      count_r <= 5'h00;
      out_r <= 1'b0;
    end else if (tick) begin
      if (count_r >= half - 5'h01) begin
        count_r <= 5'h00;
        out_r <= ~out_r;
      end else begin
        count_r <= count_r + 5'h01;
      end
    end
  end

  assign div_out = out_r;

  a_div_on_tick: assert property (@(posedge clock) disable iff (reset)
    (out_r != $past(out_r)) |-> $past(tick)) else $error("divider toggled without a tick");
  a_div_count_bound: assert property (@(posedge clock) disable iff (reset)
    $stable(half) && tick |=> count_r < half) else $error("divider count passed its ratio");

endmodule

`default_nettype wire

// ==== src/pllcfg_lock_timer.sv ====
/*
  Lock tracker for the loop model: declares lock a fixed count of cycles after the last
  restart once a reference edge has been seen, and drops it when the reference is lost.
  Assumes restart and ref_tick are one-cycle pulses on clock.
*/
`default_nettype none
`include "pllcfg_params.svh"

module pllcfg_lock_timer #(
  parameter logic [`PLLCFG_LOCK_CNT_W-1:0] LOCK_CYCLES = `PLLCFG_LOCK_CNT_W'(`PLLCFG_LOCK_CYCLES)
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic restart,
  input wire logic ref_tick,
  input wire logic ref_lost,
  output logic locked
);
  import pllcfg_pkg::*;

  pllcfg_lock_e state_r;
  logic [`PLLCFG_LOCK_CNT_W-1:0] count_r;
  logic at_end;

  assign at_end = (count_r == LOCK_CYCLES - `PLLCFG_LOCK_CNT_W'(1));

  always_ff @(posedge clock) begin
    if (reset || restart) begin
      state_r <= PLLCFG_LK_HUNT;
    end else begin
      case (state_r)
        PLLCFG_LK_HUNT: begin
          if (ref_tick) begin
            state_r <= PLLCFG_LK_SETTLE;
          end
        end
        PLLCFG_LK_SETTLE: begin
          if (ref_lost) begin
            state_r <= PLLCFG_LK_HUNT;
          end else if (at_end) begin
            state_r <= PLLCFG_LK_LOCKED;
          end
        end
        PLLCFG_LK_LOCKED: begin
          if (ref_lost) begin
            state_r <= PLLCFG_LK_HUNT;
          end
        end
        default: begin
          state_r <= PLLCFG_LK_HUNT;
        end
      endcase
    end
  end

  // The count runs from the restart, not from the first edge, so lock never comes later
  // than the lock time when the reference is already present.
  always_ff @(posedge clock) begin
    if (reset || restart || (ref_lost && state_r != PLLCFG_LK_HUNT)) begin
      count_r <= '0;
    end else if (state_r != PLLCFG_LK_LOCKED && !at_end) begin
      count_r <= count_r + `PLLCFG_LOCK_CNT_W'(1);
    end
  end

  assign locked = (state_r == PLLCFG_LK_LOCKED);

  a_lock_not_early: assert property (@(posedge clock) disable iff (reset)
    $rose(locked) |-> $past(at_end)) else $error("lock declared before the lock count ended");
  a_lock_on_time: assert property (@(posedge clock) disable iff (reset)
    (state_r == PLLCFG_LK_SETTLE && at_end && !ref_lost && !restart) |=> locked)
    else $error("lock not declared when the count ended");
  c_lock_reached: cover property (@(posedge clock) disable iff (reset) $rose(locked));

endmodule

`default_nettype wire

// ==== src/pllcfg_top.sv ====
/*
  Digital divider chain around the clock generator loop: reference selection, loop
  model, bypass, post-divider, feedback and three bank dividers, lock tracking and an
  AXI4-Lite register slave.
  Assumes one 250 MHz clock, synchronous active-high reset, and reference pins slow
  enough (well under a quarter of the clock) to be sampled as levels.
*/
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`default_nettype none
`include "pllcfg_params.svh"

module pllcfg_top #(
  parameter logic [`PLLCFG_LOCK_CNT_W-1:0] LOCK_CYCLES = `PLLCFG_LOCK_CNT_W'(`PLLCFG_LOCK_CYCLES)
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [`PLLCFG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PLLCFG_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ref_clock_in_0,
  input wire logic ref_clock_in_1,
  input wire logic crystal_reference,
  input wire logic osc_postdiv_select,
  input wire pllcfg_pkg::pllcfg_fb_sel_t feedback_ratio_select,
  input wire pllcfg_pkg::pllcfg_bank_sel_t first_bank_ratio_select,
  input wire pllcfg_pkg::pllcfg_bank_sel_t second_bank_ratio_select,
  input wire pllcfg_pkg::pllcfg_bank_sel_t third_bank_ratio_select,
  output logic first_bank_out,
  output logic second_bank_out,
  output logic third_bank_out,
  output logic loop_return_out,
  output logic pll_locked
);
  import pllcfg_pkg::*;

  localparam logic [39:0] FB_HALVES = `PLLCFG_FB_HALVES;
  localparam logic [19:0] A_HALVES = `PLLCFG_A_HALVES;
  localparam logic [19:0] B_HALVES = `PLLCFG_B_HALVES;
  localparam logic [19:0] C_HALVES = `PLLCFG_C_HALVES;

  // Pin synchronisers: every pin is asynchronous to clock.
  logic [12:0] pin_s1_r;
  logic [12:0] pin_s2_r;
  logic [2:0] ref_d_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_s1_r <= 13'h0000;
      pin_s2_r <= 13'h0000;
      ref_d_r <= 3'h0;
    end else begin
      pin_s1_r <= {crystal_reference, ref_clock_in_1, ref_clock_in_0, osc_postdiv_select, feedback_ratio_select,
                   first_bank_ratio_select, second_bank_ratio_select, third_bank_ratio_select};
      pin_s2_r <= pin_s1_r;
      ref_d_r <= pin_s2_r[12:10];
    end
  end

  logic [2:0] ref_edge;
  logic post2;
  pllcfg_fb_sel_t fb_sel;
  pllcfg_bank_sel_t a_sel;
  pllcfg_bank_sel_t b_sel;
  pllcfg_bank_sel_t c_sel;
  assign ref_edge = pin_s2_r[12:10] & ~ref_d_r;
  assign post2 = pin_s2_r[9];
  assign fb_sel = pin_s2_r[8:6];
  assign a_sel = pin_s2_r[5:4];
  assign b_sel = pin_s2_r[3:2];
  assign c_sel = pin_s2_r[1:0];

  // Control register state.
  pllcfg_src_e src_r;
  logic bypass_r;
  logic relock_r;

  logic ref_tick;
  always_comb begin
    case (src_r)
      PLLCFG_SRC_IN0: ref_tick = ref_edge[0];
      PLLCFG_SRC_IN1: ref_tick = ref_edge[1];
      default: ref_tick = ref_edge[2];
    endcase
  end

  // Ratio tables, codes ascending onto ratios.
  pllcfg_half_t fb_half;
  pllcfg_half_t a_half;
  pllcfg_half_t b_half;
  pllcfg_half_t c_half;
  assign fb_half = FB_HALVES[6'(fb_sel) * 6'h05 +: 5];
  assign a_half = A_HALVES[5'(a_sel) * 5'h05 +: 5];
  assign b_half = B_HALVES[5'(b_sel) * 5'h05 +: 5];
  assign c_half = C_HALVES[5'(c_sel) * 5'h05 +: 5];

  function automatic pllcfg_ratio_t eff_ratio(input pllcfg_half_t half, input logic by_two);
    eff_ratio = by_two ? {1'b0, half, 2'b00} : {2'b00, half, 1'b0};
  endfunction

  pllcfg_ratio_t fb_eff;
  logic cfg_err;
  assign fb_eff = eff_ratio(fb_half, post2);
  assign cfg_err = !post2 && (fb_sel > `PLLCFG_FB_DIV1_MAX_CODE);

  // Reference period measurement; a long silence counts as a lost reference.
  logic [15:0] gap_r;
  logic [15:0] period_r;
  logic ref_lost;
  assign ref_lost = (gap_r == `PLLCFG_GAP_MAX);
  always_ff @(posedge clock) begin
    if (reset) begin
      gap_r <= 16'h0000;
      period_r <= 16'h0000;
    end else if (ref_tick) begin
      gap_r <= 16'h0000;
      period_r <= ref_lost ? 16'h0000 : gap_r + 16'h0001;
    end else if (ref_lost) begin
      period_r <= 16'h0000;
    end else begin
      gap_r <= gap_r + 16'h0001;
    end
  end

  // Loop model: a rate multiplier emitting fb_eff ticks per reference period. Tick rate is
  // capped at one per clock, so oscillator rates above the clock are compressed.
  logic [15:0] acc_r;
  logic [16:0] acc_sum;
  logic [16:0] acc_diff;
  logic vco_tick;
  assign acc_sum = {1'b0, acc_r} + {9'h000, fb_eff};
  assign acc_diff = acc_sum - {1'b0, period_r};
  assign vco_tick = (period_r != 16'h0000) && (acc_sum >= {1'b0, period_r});
  always_ff @(posedge clock) begin
    if (reset || period_r == 16'h0000) begin
      acc_r <= 16'h0000;
    end else if (vco_tick) begin
      acc_r <= (acc_diff >= {1'b0, period_r}) ? period_r - 16'h0001 : acc_diff[15:0];
    end else begin
      acc_r <= acc_sum[15:0];
    end
  end

  // Bypass takes the reference edges straight into the post-divider.
  logic src_tick;
  assign src_tick = bypass_r ? ref_tick : vco_tick;

  logic post_phase_r;
  logic post_tick;
  always_ff @(posedge clock) begin
    if (reset || !post2) begin
      post_phase_r <= 1'b0;
    end else if (src_tick) begin
      post_phase_r <= ~post_phase_r;
    end
  end
  assign post_tick = src_tick && (!post2 || post_phase_r);

  // One divider per path: 0 feedback, 1 to 3 the banks, all fed from the post-divider.
  pllcfg_half_t div_half [4];
  logic [3:0] div_out;
  assign div_half[0] = fb_half;
  assign div_half[1] = a_half;
  assign div_half[2] = b_half;
  assign div_half[3] = c_half;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_div
      pllcfg_divider u_div (
        .clock(clock),
        .reset(reset),
        .tick(post_tick),
        .half(div_half[gi]),
        .div_out(div_out[gi])
      );
    end
  endgenerate
  assign loop_return_out = div_out[0];
  assign first_bank_out = div_out[1];
  assign second_bank_out = div_out[2];
  assign third_bank_out = div_out[3];

  // Any change to the loop-shaping configuration restarts lock acquisition.
  logic [5:0] cfg_q_r;
  logic cfg_changed;
  assign cfg_changed = ({post2, fb_sel, src_r} != cfg_q_r);
  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_q_r <= 6'h00;
    end else begin
      cfg_q_r <= {post2, fb_sel, src_r};
    end
  end

  pllcfg_lock_timer #(.LOCK_CYCLES(LOCK_CYCLES)) u_lock (
    .clock(clock),
    .reset(reset),
    .restart(cfg_changed || relock_r),
    .ref_tick(ref_tick),
    .ref_lost(ref_lost || cfg_err),
    .locked(pll_locked)
  );

  // AXI4-Lite write path: address and data are held independently, in either order.
  logic aw_held_r;
  logic w_held_r;
  logic [`PLLCFG_ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic do_write;
  logic wr_ctrl;
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign do_write = aw_held_r && w_held_r && !bvalid_r;
  assign wr_ctrl = do_write && (awaddr_r[3:2] == `PLLCFG_REG_CTRL >> 2) && wstrb_r[0];

  always_ff @(posedge clock) begin
    if (reset) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      bvalid_r <= 1'b0;
      bresp_r <= `PLLCFG_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= (awaddr_r[3:2] == `PLLCFG_REG_CTRL >> 2) ? `PLLCFG_RESP_OKAY : `PLLCFG_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      src_r <= pllcfg_src_e'(`PLLCFG_CTRL_SRC_RESET);
      bypass_r <= `PLLCFG_CTRL_BYPASS_RESET;
      relock_r <= 1'b0;
    end else begin
      relock_r <= wr_ctrl && wdata_r[`PLLCFG_CTRL_RELOCK_BIT];
      if (wr_ctrl) begin
        src_r <= pllcfg_src_e'(wdata_r[`PLLCFG_CTRL_SRC_LSB +: 2]);
        bypass_r <= wdata_r[`PLLCFG_CTRL_BYPASS_BIT];
      end
    end
  end

  // AXI4-Lite read path: one read outstanding, data registered.
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `PLLCFG_REG_CTRL: rd_mux = {29'h00000000, bypass_r, src_r};
      `PLLCFG_REG_STATUS: rd_mux = {28'h0000000, bypass_r, post2, cfg_err, pll_locked};
      `PLLCFG_REG_RATIO: rd_mux = {eff_ratio(c_half, post2), eff_ratio(b_half, post2),
                                   eff_ratio(a_half, post2), fb_eff};
      `PLLCFG_REG_PERIOD: rd_mux = {16'h0000, period_r};
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end
  assign s_axi_arready = !rvalid_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `PLLCFG_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? `PLLCFG_RESP_OKAY : `PLLCFG_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  a_post_pass_one: assert property (!post2 && src_tick |-> post_tick)
    else $error("post-divider by one dropped a tick");
  a_post_skip_two: assert property (post2 && $stable(post2) && post_tick |=> !post_tick until src_tick)
    else $error("post-divider by two passed back-to-back ticks");
  a_fb_ratio_set: assert property (fb_eff == {2'b00, fb_half, 1'b0} << post2)
    else $error("feedback ratio not scaled by the post-divider");
  a_code_ascend: assert property (a_sel != 2'h3 |-> a_half < A_HALVES[5'(a_sel) * 5'h05 + 5'h05 +: 5])
    else $error("bank select codes not ascending");
  a_ref_follows_sel: assert property (ref_tick |-> ref_edge[src_r == PLLCFG_SRC_IN0 ? 0 : src_r == PLLCFG_SRC_IN1 ? 1 : 2])
    else $error("reference taken from an unselected input");
  a_bypass_ref: assert property (bypass_r |-> src_tick == ref_tick)
    else $error("bypass does not feed the reference to the dividers");
  a_loop_src: assert property (!bypass_r |-> src_tick == vco_tick)
    else $error("loop output not feeding the dividers");
  a_relock_restart: assert property ($rose(relock_r) |=> !pll_locked)
    else $error("relock did not drop lock");
  a_bresp_decode: assert property (do_write && awaddr_r[3:2] != 2'h0 |=> s_axi_bresp == `PLLCFG_RESP_SLVERR)
    else $error("write to a read-only or unmapped word not refused");

  c_bypass_run: cover property (bypass_r && post_tick);
  c_post_two: cover property (post2 && post_tick ##[1:40] post_tick);
  c_unmapped_read: cover property (s_axi_rvalid && s_axi_rresp == `PLLCFG_RESP_SLVERR);

endmodule

`default_nettype wire

// ==== tb/pllcfg_board_model.sv ====
/*
  Board-side stand-in: three free-running reference clocks made from the bench clock.
  Assumes the bench clock is the design's clock and every reference stays far below a quarter of it.
*/
`default_nettype none

module pllcfg_board_model #(
  parameter int HALF0 = 24,
  parameter int HALF1 = 16,
  parameter int HALFX = 20
) (
  input wire logic clock,
  input wire logic reset,
  output logic ref_clock_in_0,
  output logic ref_clock_in_1,
  output logic crystal_reference
);
  timeunit 1ns;
  timeprecision 100ps;
  // Rates are picked so the modelled loop stays in range for every select the bench tries.
  localparam int HALF [3] = '{HALF0, HALF1, HALFX};
  int cnt [3];
  logic [2:0] lvl;
  // Oscillators run free and never change rate, so selects stay valid through lock.
  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (reset || cnt[i] == HALF[i] - 1) begin
        cnt[i] <= 0;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
      if (reset) begin
        lvl[i] <= 1'b0;
      end else if (cnt[i] == HALF[i] - 1) begin
        lvl[i] <= ~lvl[i];
      end
    end
  end
  assign ref_clock_in_0 = lvl[0];
  assign ref_clock_in_1 = lvl[1];
  assign crystal_reference = lvl[2];
endmodule

`default_nettype wire

// ==== tb/pllcfg_top_tb_top.sv ====
/*
  Self-checking bench for the divider chain: register access, ratio table, bypass, loop and lock.
  Assumes the board model supplies the references and the design runs with a short lock count.
*/
`default_nettype none
`include "pllcfg_params.svh"

module pllcfg_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pllcfg_pkg::*;
  localparam int LOCK = 200;
  localparam int FBR [7] = '{4, 6, 8, 10, 12, 16, 20};
  localparam int AR [4] = '{4, 6, 8, 12};
  localparam int BR [4] = '{4, 6, 8, 10};
  localparam int CR [4] = '{2, 4, 6, 8};
  localparam int REFP [3] = '{48, 32, 40};
  logic clock, reset, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, post, locked, r0, r1, rx;
  logic [3:0] awaddr, araddr, wstrb, outs;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, rr;
  pllcfg_fb_sel_t fb;
  pllcfg_bank_sel_t sa, sb, sc;
  int err_total, compares;

  pllcfg_top #(.LOCK_CYCLES(22'(LOCK))) i_pllcfg_top (
    .clock(clock), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ref_clock_in_0(r0), .ref_clock_in_1(r1), .crystal_reference(rx),
    .osc_postdiv_select(post), .feedback_ratio_select(fb), .first_bank_ratio_select(sa),
    .second_bank_ratio_select(sb), .third_bank_ratio_select(sc),
    .first_bank_out(outs[0]), .second_bank_out(outs[1]), .third_bank_out(outs[2]),
    .loop_return_out(outs[3]), .pll_locked(locked));

  pllcfg_board_model i_pllcfg_board_model (
    .clock(clock), .reset(reset), .ref_clock_in_0(r0), .ref_clock_in_1(r1), .crystal_reference(rx));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_near(input int got, input int exp, input int tol);
    compares++;
    if (got < exp - tol || got > exp + tol) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic timed_out;
    err_total++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 0, 1);
    results();
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) timed_out();
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) timed_out();
    d = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  task automatic rise(input int idx, output int n);
    logic prev;
    prev = outs[idx];
    for (n = 1; n < 5000; n++) begin
      @(posedge clock);
      if (outs[idx] && !prev) return;
      prev = outs[idx];
    end
    timed_out();
  endtask

  // Three intervals are taken and only the last kept, so a divider caught mid-count after a change is discarded.
  task automatic meas(input int idx, output int per);
    rise(idx, per);
    rise(idx, per);
    rise(idx, per);
  endtask

  task automatic wait_lock(output int n);
    for (n = 0; n < 2000; n++) begin
      @(posedge clock);
      if (locked === 1'b1) return;
    end
    timed_out();
  endtask

  task automatic pins(input int p, input int f, input int a, input int b, input int c);
    @(posedge clock);
    post <= 1'(p);
    fb <= 3'(f);
    sa <= 2'(a);
    sb <= 2'(b);
    sc <= 2'(c);
    repeat (4) @(posedge clock);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int per;
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, post} = 6'h00;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
    {fb, sa, sb, sc} = 9'h000;
    err_total = 0;
    compares = 0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    axi_rd(`PLLCFG_REG_CTRL, d);
    chk(d, 32'h0);
    axi_wr(`PLLCFG_REG_STATUS, 32'hf, 4'hf, r);
    chk(32'(r), 32'(`PLLCFG_RESP_SLVERR));
    axi_wr(`PLLCFG_REG_CTRL, 32'h5, 4'he, r);
    axi_rd(`PLLCFG_REG_CTRL, d);
    chk(d, 32'h0);
    axi_wr(`PLLCFG_REG_CTRL, 32'hc, 4'h1, r);
    chk(32'(r), 32'(`PLLCFG_RESP_OKAY));
    axi_rd(`PLLCFG_REG_CTRL, d);
    chk(d, 32'h4);
    chk(32'(rr), 32'(`PLLCFG_RESP_OKAY));
    axi_rd(4'h2, d);
    chk(d, 32'h0);
    chk(32'(rr), 32'(`PLLCFG_RESP_SLVERR));
    pins(0, 6, 0, 0, 0);
    axi_rd(`PLLCFG_REG_STATUS, d);
    chk(d & 32'h2, 32'h2);
    axi_rd(`PLLCFG_REG_STATUS, d);
    chk(d & 32'h8, 32'h8);
    $display("Test registers done");
    for (int p = 0; p < 2; p++) begin
      for (int f = 0; f < 6 + p; f++) begin
        pins(p, f, f % 4, (f + 1) % 4, (f + 2) % 4);
        axi_rd(`PLLCFG_REG_RATIO, d);
        chk(d, {8'((p + 1) * CR[(f + 2) % 4]), 8'((p + 1) * BR[(f + 1) % 4]),
                8'((p + 1) * AR[f % 4]), 8'((p + 1) * FBR[f])});
      end
    end
    $display("Test ratio table done");
    pins(0, 0, 0, 0, 0);
    for (int s = 0; s < 3; s++) begin
      axi_wr(`PLLCFG_REG_CTRL, 32'h4 | s, 4'h1, r);
      meas(2, per);
      chk_near(per, 2 * REFP[s], 0);
      axi_rd(`PLLCFG_REG_PERIOD, d);
      chk(d, 32'(REFP[s]));
    end
    axi_wr(`PLLCFG_REG_CTRL, 32'h4, 4'h1, r);
    pins(1, 0, 3, 3, 0);
    meas(0, per);
    chk_near(per, 24 * REFP[0], 0);
    meas(1, per);
    chk_near(per, 20 * REFP[0], 0);
    $display("Test bypass done");
    pins(0, 0, 0, 0, 0);
    axi_wr(`PLLCFG_REG_CTRL, 32'h8, 4'h1, r);
    wait_lock(per);
    chk_near(per, LOCK + 24, 30);
    meas(3, per);
    chk_near(per, REFP[0], 2);
    meas(2, per);
    chk_near(per, REFP[0] * 2 / 4, 2);
    pins(1, 0, 0, 0, 0);
    chk(32'(locked), 32'h0);
    wait_lock(per);
    chk_near(per, LOCK + 20, 30);
    meas(2, per);
    chk_near(per, REFP[0] * 2 / 4, 2);
    $display("Test loop and lock done");
    results();
  end
endmodule

`default_nettype wire
